// File: hw/mumac_pkg.sv
// What this block does
// - Modulus mode takes x then y, returns modulus then angle.
// - After modulus mode completes, first read gives modulus, next read gives angle.
// - Every angle result but the fixed arctangent one with a nonzero exponent is a signed fraction in [-1,1) standing for [-pi,pi).
// - Float modulus mode accepts y/x ratios within 2^24 and flags modulus overflow.
// - Writing the last operand the mode needs starts the computation.
// - The done flag goes to one when results are ready.
// - Two-result modes return the first result, then the second, on successive reads.
// - Halfword selects with float off mean q1.15 operands and results.
// - Arctangent mode takes one operand and returns one result.
// - Fixed arctangent result is scaled down by two to the programmed exponent.
// - Hyperbolic mode takes one operand, returns cosh then sinh.
// - Fixed hyperbolic mode returns cosh and sinh each halved.
package mumac_pkg;
  localparam logic [3:0] MODE_MODULUS = 4'h3;
  localparam logic [3:0] MODE_ATAN    = 4'h4;
  localparam logic [3:0] MODE_COSH    = 4'h5;
  localparam int         DATA_W       = 32;
  localparam int         ACC_W        = 34;
  localparam int         CIRC_STEPS   = 16;
  localparam int         HYP_STEPS    = 17;
  localparam logic [2:0] SCALE_RST    = 3'h0;
  localparam int         HYP_SHIFT    = 1;
  localparam int         FLT_BIAS     = 127;
  localparam int         FLT_EMAX     = 254;
  localparam int         RATIO_LIM    = 24;
  localparam int         ATAN_MAX_SH  = 7;
  // One in q2.31, and plus or minus pi in angle units.
  localparam logic [33:0] ONE_Q       = 34'h080000000;
  localparam logic [33:0] PI_POS      = 34'h080000000;
  localparam logic [33:0] PI_NEG      = 34'h380000000;
  localparam logic [31:0] Q31_MAX     = 32'h7FFFFFFF;
  // One over the circular gain and the hyperbolic start value 0.5 over the hyperbolic gain.
  localparam logic [31:0] KC          = 32'h4DBA76D4;
  localparam logic [31:0] HYP_X0      = 32'h4D47A1C2;
  // Arctangent of 2^-i over pi, then artanh of 2^-i, both scaled by 2^31.
  localparam logic [31:0] ATAN_TAB [16] = '{
    32'h20000000, 32'h12E4051E, 32'h09FB385B, 32'h051111D4, 32'h028B0D43, 32'h0145D7E1,
    32'h00A2F61E, 32'h00517C55, 32'h0028BE53, 32'h00145F2E, 32'h000A2F98, 32'h000517CC,
    32'h00028BE6, 32'h000145F3, 32'h0000A2FA, 32'h0000517D};
  localparam logic [31:0] HYP_TAB [16] = '{
    32'h00000000, 32'h464FA9D5, 32'h20B15DD9, 32'h1015891E, 32'h08036280, 32'h04005539,
    32'h02000AAB, 32'h01000155, 32'h0080002B, 32'h00400005, 32'h00200001, 32'h00100000,
    32'h00080000, 32'h00040000, 32'h00020000, 32'h00010000};
  typedef enum logic {OP_CIRC_VEC, OP_HYP_ROT} mumac_op_e;
  typedef enum {ST_LOAD, ST_RUN, ST_DONE} mumac_state_e;
endpackage : mumac_pkg

// File: hw/mumac_if.sv
`timescale 1ns/1ns
`default_nettype none
// Launch and result lines between the controller and the rotation engine.
interface mumac_if;
  logic                                    start;
  mumac_pkg::mumac_op_e                    op;
  logic signed [mumac_pkg::ACC_W-1:0]      x0;
  logic signed [mumac_pkg::ACC_W-1:0]      y0;
  logic signed [mumac_pkg::ACC_W-1:0]      z0;
  logic                                    done;
  logic signed [mumac_pkg::ACC_W-1:0]      xr;
  logic signed [mumac_pkg::ACC_W-1:0]      yr;
  logic signed [mumac_pkg::ACC_W-1:0]      zr;
  modport ctl (output start, op, x0, y0, z0, input done, xr, yr, zr);
  modport eng (input start, op, x0, y0, z0, output done, xr, yr, zr);
endinterface : mumac_if
`default_nettype wire

// File: hw/mumac_cordic.sv
`timescale 1ns/1ns
`default_nettype none
module mumac_cordic (
  input wire logic sys_clk,
  input wire logic resetn,
  mumac_if.eng     bus
);
  import mumac_pkg::*;

  logic signed [ACC_W-1:0] x_ff, y_ff, z_ff;
  logic signed [ACC_W-1:0] xs, ys, ang;
  logic        [4:0]       k_ff, idx, last;
  logic                    run_ff, done_ff, dir, neg;
  mumac_op_e               op_ff;

  // Hyperbolic steps repeat shifts 4 and 13 so that the sum converges.
  function automatic logic [4:0] hyp_idx(input logic [4:0] k);
    if (k < 5'h04) begin
      hyp_idx = 5'(k + 5'h01);
    end else if (k < 5'h0E) begin
      hyp_idx = k;
    end else begin
      hyp_idx = 5'(k - 5'h01);
    end
  endfunction : hyp_idx

  ////////////////////////////////////////////////////////////////////////////
  // Step decode; vectoring follows the sign of y, rotation the sign of z.
  always_comb begin
    idx  = (op_ff == OP_HYP_ROT) ? hyp_idx(k_ff) : k_ff;
    ang  = (op_ff == OP_HYP_ROT) ? {2'b00, HYP_TAB[idx[3:0]]} : {2'b00, ATAN_TAB[idx[3:0]]};
    xs   = x_ff >>> idx;
    ys   = y_ff >>> idx;
    dir  = (op_ff == OP_HYP_ROT) ? ~z_ff[ACC_W-1] : ~y_ff[ACC_W-1];
    neg  = (op_ff == OP_HYP_ROT) ? ~dir : dir;
    last = (op_ff == OP_HYP_ROT) ? 5'(HYP_STEPS - 1) : 5'(CIRC_STEPS - 1);
  end

  // Datapath, one shift-add step per clock.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      x_ff  <= '0;
      y_ff  <= '0;
      z_ff  <= '0;
      op_ff <= OP_CIRC_VEC;
    end else if (bus.start) begin
      x_ff  <= bus.x0;
      y_ff  <= bus.y0;
      z_ff  <= bus.z0;
      op_ff <= bus.op;
    end else if (run_ff) begin
      x_ff  <= dir ? x_ff + ys : x_ff - ys;
      y_ff  <= neg ? y_ff - xs : y_ff + xs;
      z_ff  <= neg ? z_ff + ang : z_ff - ang;
    end
  end

  // Step counter and the one-cycle done pulse.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_ff  <= 1'b0;
      k_ff    <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= run_ff && (k_ff == last);
      if (bus.start) begin
        run_ff <= 1'b1;
        k_ff   <= '0;
      end else if (run_ff) begin
        run_ff <= (k_ff != last);
        k_ff   <= 5'(k_ff + 5'h01);
      end
    end
  end

  assign bus.done = done_ff;
  assign bus.xr   = x_ff;
  assign bus.yr   = y_ff;
  assign bus.zr   = z_ff;

  property p_eng_len;
    @(posedge sys_clk) disable iff (!resetn)
      (bus.start && bus.op == OP_HYP_ROT) |=> (!bus.done) [*8] ##10 bus.done;
  endproperty
  a_eng_len: assert property (p_eng_len) else $error("hyperbolic run length wrong");
endmodule : mumac_cordic
`default_nettype wire

// File: hw/mumac_top.sv
`timescale 1ns/1ns
`default_nettype none
module mumac_top (
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  input  wire logic [3:0]                   mode,
  input  wire logic                         input_float_enable,
  input  wire logic                         output_float_enable,
  input  wire logic                         input_halfword_select,
  input  wire logic                         output_halfword_select,
  input  wire logic [2:0]                   scale_exp,
  input  wire logic                         wr_stb,
  input  wire logic [mumac_pkg::DATA_W-1:0] operand_write_port,
  input  wire logic                         rd_stb,
  output logic      [mumac_pkg::DATA_W-1:0] result_read_port,
  output logic                              calc_done_flag,
  output logic                              overflow_flag,
  output logic                              busy
);
  import mumac_pkg::*;
  default clocking cb_asrt @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  mumac_if bus ();

  mumac_cordic u_cordic (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .bus     (bus.eng)
  );

  mumac_state_e            state_ff;
  logic                    cnt_ff, start_ff, flt_ff, hw_out_ff, rd_idx_ff, two_ff;
  logic                    calc_done_flag_ff, overflow_flag_ff, busy_ff;
  logic [3:0]              mode_ff;
  logic [DATA_W-1:0]       op0_ff, res0_ff, res1_ff, rd_data_ff;
  logic signed [9:0]       sh_ff;
  mumac_op_e               op_ff;
  logic signed [ACC_W-1:0] x0_ff, y0_ff, z0_ff;

  logic                    flt, accept, supported, launch, last_rd;
  logic signed [ACC_W-1:0] nxt_x0, nxt_y0, nxt_z0, a_fx, b_fx, m_fx, z_wr;
  logic signed [9:0]       nxt_sh;
  logic [7:0]              ex, ey, emax;
  logic                    nxt_ratio_ovf;
  logic [DATA_W-1:0]       nxt_res0, nxt_res1;
  logic                    nxt_ovf;
  logic [32:0]             f0, f1;
  logic signed [67:0]      prod;

  // Operand in: q1.15 in the low halfword moves to the top of a q1.31 word.
  function automatic logic signed [ACC_W-1:0] fix_in(input logic [31:0] w, input logic hw);
    fix_in = hw ? {{2{w[15]}}, w[15:0], 16'h0000} : {{2{w[31]}}, w};
  endfunction : fix_in

  // Single float to q2.31 divided by 2^s; denormals count as zero.
  function automatic logic signed [ACC_W-1:0] flt2fix(input logic [31:0] w, input logic signed [9:0] s);
    int          sh;
    logic [63:0] mag;
    sh  = int'(w[30:23]) - 119 - int'(s);
    mag = 64'({1'b1, w[22:0]});
    if (w[30:23] == 8'h00) begin
      mag = '0;
    end else if (sh >= 0) begin
      mag = mag << ((sh > 10) ? 10 : sh);
    end else begin
      mag = mag >> ((-sh > 40) ? 40 : -sh);
    end
    flt2fix = w[31] ? -$signed(mag[ACC_W-1:0]) : $signed(mag[ACC_W-1:0]);
  endfunction : flt2fix

  // q2.31 times 2^e to single float, truncating; bit 32 flags exponent overflow.
  function automatic logic [32:0] fix2flt(input logic signed [ACC_W-1:0] v, input logic signed [9:0] e);
    logic [ACC_W-1:0] mag, nrm;
    int               p, ex_f;
    mag = v[ACC_W-1] ? ACC_W'(-v) : ACC_W'(v);
    p   = 0;
    for (int i = 0; i < ACC_W; i++) begin
      if (mag[i]) begin
        p = i;
      end
    end
    nrm  = mag << (ACC_W - 1 - p);
    ex_f = p - 31 + int'(e) + FLT_BIAS;
    if (mag == '0 || ex_f < 1) begin
      fix2flt = '0;
    end else if (ex_f > FLT_EMAX) begin
      fix2flt = {1'b1, v[ACC_W-1], 8'hFF, 23'h000000};
    end else begin
      fix2flt = {1'b0, v[ACC_W-1], 8'(ex_f), nrm[ACC_W-2:ACC_W-24]};
    end
  endfunction : fix2flt
  ////////////////////////////////////////////////////////////////////////////
  // Float only when both enables are set; a mixed setting is fixed point.
  always_comb begin
    flt       = input_float_enable && output_float_enable;
    supported = (mode == MODE_MODULUS) || (mode == MODE_ATAN) || (mode == MODE_COSH);
    accept    = wr_stb && supported && (state_ff != ST_RUN);
    launch    = accept && ((mode != MODE_MODULUS) || cnt_ff);
    last_rd   = rd_stb && calc_done_flag_ff && (rd_idx_ff == two_ff);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start values for the engine, built from the operands as they arrive.
  always_comb begin
    a_fx          = fix_in(op0_ff, input_halfword_select);
    b_fx          = fix_in(operand_write_port, input_halfword_select);
    ex            = op0_ff[30:23];
    ey            = operand_write_port[30:23];
    emax          = (ex > ey) ? ex : ey;
    nxt_ratio_ovf = 1'b0;
    nxt_sh        = '0;
    nxt_z0        = '0;
    nxt_x0        = ONE_Q;
    nxt_y0        = b_fx;
    if (mode == MODE_MODULUS) begin
      if (flt) begin
        // Both operands share one exponent so the angle is kept exact.
        nxt_sh        = 10'(int'(emax) - 126);
        nxt_x0        = flt2fix(op0_ff, nxt_sh);
        nxt_y0        = flt2fix(operand_write_port, nxt_sh);
        nxt_ratio_ovf = (ex != 8'h00) && (ey != 8'h00) &&
                        (((ex > ey) ? ex - ey : ey - ex) > 8'(RATIO_LIM));
      end else begin
        nxt_x0 = a_fx;
      end
      // Left half-plane vectors are turned by pi first; z then wraps into [-1,1).
      if (nxt_x0[ACC_W-1]) begin
        nxt_z0 = nxt_y0[ACC_W-1] ? $signed(PI_NEG) : $signed(PI_POS);
        nxt_x0 = -nxt_x0;
        nxt_y0 = -nxt_y0;
      end
    end else if (mode == MODE_ATAN) begin
      // atan(y/(2^-f)) equals atan(x); with float off the angle is shifted down by f later.
      if (flt) begin
        nxt_sh = (int'(operand_write_port[30:23]) > 126 + ATAN_MAX_SH) ? 10'(ATAN_MAX_SH) :
                 (operand_write_port[30:23] > 8'd126) ? 10'(int'(operand_write_port[30:23]) - 126) : '0;
        nxt_y0 = flt2fix(operand_write_port, nxt_sh);
      end else begin
        nxt_sh = 10'(scale_exp);
      end
      nxt_x0 = $signed(ONE_Q) >>> nxt_sh;
    end else begin
      // The engine needs the full angle, so the halved fixed operand is doubled.
      nxt_x0 = {2'b00, HYP_X0};
      nxt_y0 = '0;
      nxt_sh = 10'(HYP_SHIFT);
      nxt_z0 = flt ? flt2fix(operand_write_port, '0) : (b_fx <<< HYP_SHIFT);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Results from the engine, in the number format chosen at launch.
  always_comb begin
    prod     = $signed(bus.xr) * $signed({2'b00, KC, 2'b00}) >>> 2;
    m_fx     = prod[ACC_W+30:31];
    z_wr     = {{2{bus.zr[31]}}, bus.zr[31:0]};
    f0       = '0;
    f1       = '0;
    nxt_ovf  = 1'b0;
    nxt_res0 = '0;
    nxt_res1 = '0;
    case (mode_ff)
      MODE_MODULUS: begin
        f0       = fix2flt(m_fx, sh_ff);
        f1       = fix2flt(z_wr, '0);
        nxt_ovf  = flt_ff && f0[32];
        nxt_res0 = flt_ff ? f0[31:0] : ((m_fx >= $signed(ONE_Q)) ? Q31_MAX : m_fx[31:0]);
        nxt_res1 = flt_ff ? f1[31:0] : bus.zr[31:0];
      end
      MODE_ATAN: begin
        f0       = fix2flt(bus.zr, '0);
        nxt_res0 = flt_ff ? f0[31:0] : 32'(bus.zr >>> sh_ff);
      end
      MODE_COSH: begin
        f0       = fix2flt(bus.xr, sh_ff);
        f1       = fix2flt(bus.yr, sh_ff);
        nxt_ovf  = flt_ff && (f0[32] || f1[32]);
        nxt_res0 = flt_ff ? f0[31:0] : bus.xr[31:0];
        nxt_res1 = flt_ff ? f1[31:0] : bus.yr[31:0];
      end
      default: nxt_res0 = '0;
    endcase
    if (hw_out_ff && !flt_ff) begin
      nxt_res0 = {16'h0000, nxt_res0[31:16]};
      nxt_res1 = {16'h0000, nxt_res1[31:16]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Operand sequencing and launch of the engine.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff    <= 1'b0;
      op0_ff    <= '0;
      start_ff  <= 1'b0;
      op_ff     <= OP_CIRC_VEC;
      x0_ff     <= '0;
      y0_ff     <= '0;
      z0_ff     <= '0;
      sh_ff     <= '0;
      mode_ff   <= '0;
      flt_ff    <= 1'b0;
      hw_out_ff <= 1'b0;
      two_ff    <= 1'b0;
    end else begin
      start_ff <= launch;
      if (accept && !launch) begin
        cnt_ff <= 1'b1;
        op0_ff <= operand_write_port;
      end
      if (launch) begin
        cnt_ff    <= 1'b0;
        op_ff     <= (mode == MODE_COSH) ? OP_HYP_ROT : OP_CIRC_VEC;
        x0_ff     <= nxt_x0;
        y0_ff     <= nxt_y0;
        z0_ff     <= nxt_z0;
        sh_ff     <= nxt_sh;
        mode_ff   <= mode;
        flt_ff    <= flt;
        hw_out_ff <= output_halfword_select;
        two_ff    <= (mode != MODE_ATAN);
      end
    end
  end

  assign bus.start = start_ff;
  assign bus.op    = op_ff;
  assign bus.x0    = x0_ff;
  assign bus.y0    = y0_ff;
  assign bus.z0    = z0_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Control state, done flag and overflow flag.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff          <= ST_LOAD;
      calc_done_flag_ff <= 1'b0;
      overflow_flag_ff  <= 1'b0;
      busy_ff           <= 1'b0;
      res0_ff           <= '0;
      res1_ff           <= '0;
    end else begin
      case (state_ff)
        ST_LOAD, ST_DONE: begin
          if (launch) begin
            // A new launch drops any unread results of the previous run.
            state_ff          <= ST_RUN;
            calc_done_flag_ff <= 1'b0;
            overflow_flag_ff  <= nxt_ratio_ovf && (mode == MODE_MODULUS) && flt;
            busy_ff           <= 1'b1;
          end else if (last_rd) begin
            state_ff          <= ST_LOAD;
            calc_done_flag_ff <= 1'b0;
          end
        end
        ST_RUN: begin
          if (bus.done) begin
            state_ff          <= ST_DONE;
            calc_done_flag_ff <= 1'b1;
            busy_ff           <= 1'b0;
            overflow_flag_ff  <= overflow_flag_ff || nxt_ovf;
            res0_ff           <= nxt_res0;
            res1_ff           <= nxt_res1;
          end
        end
        default: begin
          state_ff <= ST_LOAD;
        end
      endcase
    end
  end

  // Read port: results in order; reads without results give zero.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_idx_ff  <= 1'b0;
      rd_data_ff <= '0;
    end else begin
      rd_idx_ff <= launch ? 1'b0 : (rd_stb ? (calc_done_flag_ff && !last_rd) : rd_idx_ff);
      if (rd_stb) begin
        rd_data_ff <= !calc_done_flag_ff ? '0 : (rd_idx_ff ? res1_ff : res0_ff);
      end
    end
  end

  assign result_read_port = rd_data_ff;
  assign calc_done_flag   = calc_done_flag_ff;
  assign overflow_flag    = overflow_flag_ff;
  assign busy             = busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  property p_first_read;
    (rd_stb && calc_done_flag && !rd_idx_ff) |=> (result_read_port == $past(res0_ff));
  endproperty
  a_first_read: assert property (p_first_read) else $error("first read not first result");
  property p_second_read;
    (rd_stb && calc_done_flag && rd_idx_ff) |=> (result_read_port == $past(res1_ff));
  endproperty
  a_second_read: assert property (p_second_read) else $error("second read not second result");
  property p_start_on_last;
    launch |=> busy && !calc_done_flag;
  endproperty
  a_start_on_last: assert property (p_start_on_last) else $error("last operand did not start");
  property p_no_early_start;
    (accept && mode == MODE_MODULUS && !cnt_ff) |=> !busy;
  endproperty
  a_no_early_start: assert property (p_no_early_start) else $error("started on first operand");
  property p_done_bound;
    launch |=> ##[16:20] calc_done_flag;
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("done flag late");
  property p_clear_on_last;
    (last_rd && !launch) |=> !calc_done_flag;
  endproperty
  a_clear_on_last: assert property (p_clear_on_last) else $error("done not cleared");
  property p_cosh_half;
    $rose(calc_done_flag) && mode_ff == MODE_COSH && !flt_ff && !hw_out_ff |-> res0_ff[31:30] == 2'b01;
  endproperty
  a_cosh_half: assert property (p_cosh_half) else $error("cosh not halved");
  property p_modulus_pos;
    $rose(calc_done_flag) && mode_ff == MODE_MODULUS && !flt_ff |-> !res0_ff[31];
  endproperty
  a_modulus_pos: assert property (p_modulus_pos) else $error("modulus negative");
  property p_q15_out;
    (rd_stb && calc_done_flag && hw_out_ff && !flt_ff) |=> result_read_port[31:16] == 16'h0000;
  endproperty
  a_q15_out: assert property (p_q15_out) else $error("q1.15 result not in low half");

  c_modulus: cover property (@(posedge sys_clk) disable iff (!resetn) launch && mode == MODE_MODULUS);
  c_atan:    cover property (@(posedge sys_clk) disable iff (!resetn) launch && mode == MODE_ATAN);
  c_cosh_rd: cover property (@(posedge sys_clk) disable iff (!resetn) last_rd && mode_ff == MODE_COSH);
endmodule : mumac_top
`default_nettype wire

// File: tb/mumac_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mumac_tb;
  import mumac_pkg::*;
  logic                sys_clk;
  logic                resetn;
  logic [3:0]          mode;
  logic                input_float_enable;
  logic                output_float_enable;
  logic                input_halfword_select;
  logic                output_halfword_select;
  logic [2:0]          scale_exp;
  logic                wr_stb;
  logic [DATA_W-1:0]   operand_write_port;
  logic                rd_stb;
  logic [DATA_W-1:0]   result_read_port;
  logic                calc_done_flag;
  logic                overflow_flag;
  logic                busy;
  int                  error_cnt;
  int                  compares;
  mumac_top dut (.sys_clk(sys_clk), .resetn(resetn), .mode(mode), .input_float_enable(input_float_enable),
    .output_float_enable(output_float_enable), .input_halfword_select(input_halfword_select),
    .output_halfword_select(output_halfword_select), .scale_exp(scale_exp), .wr_stb(wr_stb),
    .operand_write_port(operand_write_port), .rd_stb(rd_stb), .result_read_port(result_read_port),
    .calc_done_flag(calc_done_flag), .overflow_flag(overflow_flag), .busy(busy));
  // Free running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Results are approximate, so every compare carries a tolerance; zero means exact.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] tol);
    logic [31:0] d;
    compares++;
    d = (seen > exp) ? seen - exp : exp - seen;
    if ((^seen === 1'bx) || (d > tol)) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d.", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic set_cfg(input logic [3:0] m, input logic fl, input logic hw, input logic [2:0] f);
    @(negedge sys_clk);
    mode = m;
    input_float_enable = fl;
    output_float_enable = fl;
    input_halfword_select = hw;
    output_halfword_select = hw;
    scale_exp = f;
  endtask : set_cfg
  // The data lines get the inverse after the pulse so a stale value cannot be reused.
  task automatic wr(input logic [31:0] d);
    @(negedge sys_clk);
    wr_stb = 1'b1;
    operand_write_port = d;
    @(negedge sys_clk);
    wr_stb = 1'b0;
    operand_write_port = ~d;
  endtask : wr
  // Counts cycles from the negedge it is called on; a lost completion ends the run.
  task automatic wait_done(input int exp_k);
    int k;
    k = 1;
    @(negedge sys_clk);
    check({31'h0, calc_done_flag}, 32'h0, 32'h0);
    while (calc_done_flag !== 1'b1 && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    check(k, exp_k, 32'h2);
    if (k >= 40)
      stop_test();
  endtask : wait_done
  task automatic rd(input logic [31:0] exp, input logic [31:0] tol);
    @(negedge sys_clk);
    rd_stb = 1'b1;
    @(negedge sys_clk);
    rd_stb = 1'b0;
    @(negedge sys_clk);
    check(result_read_port, exp, tol);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  // Fixed vector (5,80)/128: only the second operand may start the engine.
  task automatic t_mod_fixed();
    set_cfg(MODE_MODULUS, 1'b0, 1'b1, SCALE_RST);
    rd(32'h0, 32'h0);
    wr(32'h0000_0500);
    @(negedge sys_clk);
    check({31'h0, busy}, 32'h0, 32'h0);
    wr(32'h0000_5000);
    wait_done(18);
    rd(32'h0000_5028, 32'h8);
    rd(32'h0000_3D75, 32'h8);
    check({31'h0, calc_done_flag}, 32'h0, 32'h0);
  endtask : t_mod_fixed
  // Float vector (3,4), then a ratio of 2^30 that must overflow.
  task automatic t_mod_float();
    set_cfg(MODE_MODULUS, 1'b1, 1'b0, SCALE_RST);
    wr(32'h4040_0000);
    wr(32'h4080_0000);
    wait_done(18);
    check({31'h0, overflow_flag}, 32'h0, 32'h0);
    rd(32'h40A0_0000, 32'h100);
    rd(32'h3E97_2028, 32'h200);
    wr(32'h3F80_0000);
    wr(32'h4E80_0000);
    wait_done(18);
    check({31'h0, overflow_flag}, 32'h1, 32'h0);
    rd(32'h4E80_0000, 32'h100);
    rd(32'h3F00_0000, 32'h400);
  endtask : t_mod_float
  // Arctangent of 100 scaled by 2^7, then of 0.5 in q1.31 with a write during the run.
  task automatic t_atan();
    set_cfg(MODE_ATAN, 1'b0, 1'b1, 3'h7);
    wr(32'h0000_6400);
    wait_done(18);
    rd(32'h0000_007F, 32'h4);
    check({31'h0, calc_done_flag}, 32'h0, 32'h0);
    set_cfg(MODE_ATAN, 1'b0, 1'b0, SCALE_RST);
    wr(32'h4000_0000);
    wr(32'h7FFF_FFFF);
    wait_done(16);
    rd(32'h12E4_051E, 32'h0002_0000);
  endtask : t_atan
  // Hyperbolic pair of 1.0; the second launch drops the first pending pair.
  task automatic t_cosh();
    set_cfg(MODE_COSH, 1'b0, 1'b1, 3'h1);
    wr(32'h0000_4000);
    wait_done(19);
    wr(32'h0000_4000);
    wait_done(19);
    rd(32'h0000_62C2, 32'h8);
    rd(32'h0000_4B37, 32'h8);
    check({31'h0, calc_done_flag}, 32'h0, 32'h0);
  endtask : t_cosh
  // Float arctangent of 1.0, then the float hyperbolic pair of 1.0, scale field left at zero.
  task automatic t_float_fn();
    set_cfg(MODE_ATAN, 1'b1, 1'b0, SCALE_RST);
    wr(32'h3F80_0000);
    wait_done(18);
    rd(32'h3E80_0000, 32'h800);
    set_cfg(MODE_COSH, 1'b1, 1'b0, SCALE_RST);
    wr(32'h3F80_0000);
    wait_done(19);
    rd(32'h3FC5_83AA, 32'h400);
    rd(32'h3F96_6CFE, 32'h400);
    check({31'h0, overflow_flag}, 32'h0, 32'h0);
  endtask : t_float_fn
  // Inputs settle at time zero, reset holds for 16 cycles, then the scenarios run.
  initial begin
    error_cnt = 0;
    compares = 0;
    resetn = 1'b0;
    mode = 4'h0;
    input_float_enable = 1'b0;
    output_float_enable = 1'b0;
    input_halfword_select = 1'b0;
    output_halfword_select = 1'b0;
    scale_exp = SCALE_RST;
    wr_stb = 1'b0;
    operand_write_port = 32'h0;
    rd_stb = 1'b0;
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    t_mod_fixed();
    t_mod_float();
    t_atan();
    t_cosh();
    t_float_fn();
    stop_test();
  end
endmodule : mumac_tb
`default_nettype wire
